/* rtl/spi_port_pkg.sv */
// Overview of operation
// (R01) Master owns the serial clock and may start a transfer at any time.
// (R02) Master: an accepted buffer write starts an eight-clock full-duplex byte.
// (R03) Receive-only master still shifts input and loads the buffer, setting flags.
// (R04) Master bit rate is clock/4, /16, /64 or timer-two output/2.
// (R05) Bytes are shifted most significant bit first in both directions.
// (R06) With edge select set, the first output bit is valid before any clock edge.
// (R07) Slave shifts only on external clock edges; last bit latched sets done flag.
// (R08) External master holds the clock at idle level before slave enable.
// (R09) Select-controlled slave works and drives output only while select is low.
// (R10) Select rising stops driving the serial output at once, even mid-byte; the output floats two clocks after the pin rises.
// (R11) Select high in mode 0100, or port disable, forces bit counter to zero.
// (R12) Software enables select control when slave runs with edge select set.
// (R13) Master in sleep freezes its clocks and resumes afterwards.
// (R14) Slave keeps shifting in sleep; byte end sets flag and wakes if enabled.
// (R15) Device reset disables the port and aborts any transfer.
// (R16) SPI modes: 0,0=pol0 edge1; 0,1=pol0 edge0; 1,0=pol1 edge1; 1,1=pol1 edge0.
// (R17) Completed byte moves to the buffer and sets the done flag at once.
// (R18) A buffer write loads buffer and shift register together.
// (R19) Output pin configured as input stops transmission; input never drives.
// (R20) Mode field: 0-2 master /4,/16,/64; 3 timer master; 4, 5 slave.
// (R21) Buffer write during a transfer is ignored and sets write collision.
// (R22) Slave byte arriving over an unread buffer sets overflow and is lost.
// (R23) Master samples at end of bit time with sample phase 1, else middle.
// (R24) External clock, select and input are synchronised before use.
// (R25) Done flag stays until software clears it; buffer read clears full bit.
package spi_port_pkg;

  // ==========================================================================
  // Register map (word index on the register port)
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS  = 2'h1;
  localparam logic [1:0] ADDR_BUFFER  = 2'h2;
  localparam logic [1:0] ADDR_AUX     = 2'h3;

  localparam int CTL_WRITE_COLLISION   = 7;
  localparam int CTL_OVF    = 6;
  localparam int CTL_EN     = 5;
  localparam int CTL_CKP    = 4;
  localparam int STA_SMP    = 7;
  localparam int STA_CKE    = 6;
  localparam int STA_BF     = 0;
  localparam int AUX_TDF    = 0;
  localparam int AUX_IRQ_EN = 1;

  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] AUX_RST     = 8'h00;
  localparam logic [7:0] BUFFER_RST  = 8'h00;

  // ==========================================================================
  // Modes and rates
  typedef enum logic [3:0] {
    MODE_M_DIV4  = 4'h0,
    MODE_M_DIV16 = 4'h1,
    MODE_M_DIV64 = 4'h2,
    MODE_M_TIMER_TWO_OUTPUT  = 4'h3,
    MODE_S_SEL   = 4'h4,
    MODE_S_NOSEL = 4'h5
  } port_mode_t;

  typedef enum logic {
    M_IDLE = 1'b0,
    M_RUN  = 1'b1
  } m_state_t;

  // Oscillator cycles per serial bit; half of it is one clock phase
  localparam int OSC_PER_BIT_DIV4  = 4;
  localparam int OSC_PER_BIT_DIV16 = 16;
  localparam int OSC_PER_BIT_DIV64 = 64;
  localparam int HALF_DIV4_CYC     = OSC_PER_BIT_DIV4 / 2;
  localparam int HALF_DIV16_CYC    = OSC_PER_BIT_DIV16 / 2;
  localparam int HALF_DIV64_CYC    = OSC_PER_BIT_DIV64 / 2;

  localparam int         BYTE_BITS  = 8;
  localparam logic [4:0] HALF_LAST  = 5'(2 * BYTE_BITS - 1);
  localparam logic [4:0] HALF_EXTRA = 5'(2 * BYTE_BITS);
  localparam logic [2:0] BIT_LAST   = 3'(BYTE_BITS - 1);

endpackage

/* rtl/spi_rate_gen.sv */
`timescale 1ns/1ps
module spi_rate_gen
  import spi_port_pkg::*;
(
  // Clock and reset
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  // Timer pulse, same clock domain
  input  wire logic   timer_two_output_i,
  // Rate control
  spi_rate_if.gen     rate
);

  logic [4:0] cnt_q;
  logic [4:0] half_lim;

  always_comb begin
    case (rate.sel)
      2'h0:    half_lim = 5'(HALF_DIV4_CYC - 1);
      2'h1:    half_lim = 5'(HALF_DIV16_CYC - 1);
      2'h2:    half_lim = 5'(HALF_DIV64_CYC - 1);
      default: half_lim = 5'h00;
    endcase
  end

  // One tick per serial clock phase; hold freezes it for sleep
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q     <= 5'h00;
      rate.tick <= 1'b0;
    end else if (!rate.run) begin
      cnt_q     <= 5'h00;
      rate.tick <= 1'b0;
    end else if (rate.hold) begin
      rate.tick <= 1'b0;
    end else if (rate.sel == 2'h3) begin
      rate.tick <= timer_two_output_i; // [R04]
    end else if (cnt_q == half_lim) begin
      cnt_q     <= 5'h00;
      rate.tick <= 1'b1; // [R04]
    end else begin
      cnt_q     <= cnt_q + 5'h01;
      rate.tick <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_div4_tick_spacing: assert property ( // [R04]
    (rate.tick && rate.sel == 2'h0 && rate.run && !rate.hold)
      ##1 (rate.sel == 2'h0 && rate.run && !rate.hold) |-> !rate.tick ##1 rate.tick)
    else $error("divide-by-4 phase tick not two cycles apart");

endmodule

/* rtl/spi_rate_if.sv */
`timescale 1ns/1ps
interface spi_rate_if;
  logic       run;
  logic       hold;
  logic [1:0] sel;
  logic       tick;

  modport gen  (input run, hold, sel, output tick);
  modport user (output run, hold, sel, input tick);
endinterface

/* rtl/sync_serial_spi_port.sv */
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module sync_serial_spi_port
  import spi_port_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [1:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // System
  input  wire logic       sleep_i,
  input  wire logic       timer_two_output_i,
  input  wire logic       sdo_as_input_i,
  output logic            transfer_done_o,
  output logic            wake_o,
  // Serial pins
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_o,
  input  wire logic       serial_input_i,
  output logic            serial_output_o,
  output logic            serial_output_oe_o,
  input  wire logic       slave_select_n_i
);

  // ==========================================================================
  // Registers
  logic       en_q, ckp_q, smp_q, cke_q;
  logic [3:0] mode_q;
  logic       write_collision_q, ovf_q, bf_q, tdf_q, irq_en_q;
  logic [7:0] buf_q, sr_q, rdata_q;
  logic       sdo_q, sck_q;
  m_state_t   m_state_q;
  logic [4:0] half_cnt_q;
  logic       pend_q;
  logic [2:0] bit_cnt_q;

  // ==========================================================================
  // Pin synchronisers: {clock, select, data}
  logic [2:0] pin_meta_q, pin_sync_q;
  logic       sck_prev_q;
  logic       sck_s, ss_n_s, sdi_s;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_q <= 3'h2;
      pin_sync_q <= 3'h2;
      sck_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= {sck_i, slave_select_n_i, serial_input_i}; // [R24]
      pin_sync_q <= pin_meta_q;
      sck_prev_q <= pin_sync_q[2];
    end
  end

  assign sck_s  = pin_sync_q[2];
  assign ss_n_s = pin_sync_q[1];
  assign sdi_s  = pin_sync_q[0];

  // ==========================================================================
  // Decode
  logic is_master, is_slave, ss_mode, ss_active, slave_go;
  logic wr_ctl, wr_sta, wr_buf, wr_aux, rd_buf;
  logic m_run, busy, wr_accept;

  assign is_master = en_q && (mode_q <= 4'(MODE_M_TIMER_TWO_OUTPUT)); // [R20]
  assign is_slave  = en_q && (mode_q == 4'(MODE_S_SEL) || mode_q == 4'(MODE_S_NOSEL));
  assign ss_mode   = en_q && (mode_q == 4'(MODE_S_SEL));
  assign ss_active = !ss_mode || !ss_n_s; // [R09]
  assign slave_go  = is_slave && ss_active;

  assign wr_ctl = reg_wr_i && reg_addr_i == ADDR_CONTROL;
  assign wr_sta = reg_wr_i && reg_addr_i == ADDR_STATUS;
  assign wr_buf = reg_wr_i && reg_addr_i == ADDR_BUFFER;
  assign wr_aux = reg_wr_i && reg_addr_i == ADDR_AUX;
  assign rd_buf = reg_rd_i && reg_addr_i == ADDR_BUFFER;

  assign m_run     = m_state_q == M_RUN;
  assign busy      = m_run || bit_cnt_q != 3'h0;
  assign wr_accept = wr_buf && !busy;

  // ==========================================================================
  // Rate generator for the master clock
  spi_rate_if rate ();

  assign rate.run  = is_master && m_run; // [R01]
  assign rate.hold = sleep_i; // [R13]
  assign rate.sel  = mode_q[1:0];

  spi_rate_gen u_rate (
    .sys_clk_i          (sys_clk_i),
    .rst_i              (rst_i),
    .timer_two_output_i (timer_two_output_i),
    .rate               (rate)
  );

  // ==========================================================================
  // Clock edges: leading leaves the idle level, trailing returns to it
  logic m_tick, m_lead, m_trail, m_end, m_done;
  logic s_chg, lead, trail, sample_edge, xmit_edge, do_shift, complete;
  logic [7:0] shifted;

  assign m_tick  = is_master && m_run && rate.tick;
  assign m_lead  = m_tick && half_cnt_q < HALF_EXTRA && !half_cnt_q[0];
  assign m_trail = m_tick && half_cnt_q < HALF_EXTRA && half_cnt_q[0];
  assign m_end   = m_tick && half_cnt_q == HALF_EXTRA;
  assign m_done  = m_tick && half_cnt_q == (smp_q ? HALF_EXTRA : HALF_LAST);
  assign s_chg   = slave_go && (sck_s != sck_prev_q); // [R07]

  // Polarity and edge select give the four standard modes
  assign lead  = m_lead || (s_chg && sck_prev_q == ckp_q); // [R16]
  assign trail = m_trail || (s_chg && sck_prev_q != ckp_q);
  assign sample_edge = cke_q ? lead : trail;
  assign xmit_edge   = cke_q ? trail : lead;

  // Late sampling waits for the next phase tick (end of the bit time)
  assign do_shift = (is_master && smp_q) ? (pend_q && (xmit_edge || m_end))
                                         : sample_edge; // [R23]
  assign complete = do_shift && bit_cnt_q == BIT_LAST;
  assign shifted  = {sr_q[6:0], sdi_s}; // [R05]

  // ==========================================================================
  // Master sequencing
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      m_state_q  <= M_IDLE; // [R15]
      half_cnt_q <= 5'h00;
    end else if (!is_master) begin
      m_state_q  <= M_IDLE;
      half_cnt_q <= 5'h00;
    end else begin
      case (m_state_q)
        M_IDLE: begin
          if (wr_accept) begin
            m_state_q  <= M_RUN; // [R02]
            half_cnt_q <= 5'h00;
          end
        end
        M_RUN: begin
          if (m_done) begin
            m_state_q <= M_IDLE;
          end else if (m_tick) begin
            half_cnt_q <= half_cnt_q + 5'h01;
          end
        end
        default: m_state_q <= M_IDLE;
      endcase
    end
  end

  // Clock pin follows the phase count; ticks stop in sleep so it freezes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q <= 1'b0;
    end else if (!m_run) begin
      sck_q <= ckp_q;
    end else if (m_lead) begin
      sck_q <= !ckp_q; // [R13]
    end else if (m_trail) begin
      sck_q <= ckp_q;
    end
  end

  // ==========================================================================
  // Shift path and bit counter
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_q <= 3'h0;
      pend_q    <= 1'b0;
    end else if (!en_q || (ss_mode && ss_n_s)) begin
      bit_cnt_q <= 3'h0; // [R11]
      pend_q    <= 1'b0;
    end else begin
      if (do_shift) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (is_master && smp_q && sample_edge) begin
        pend_q <= 1'b1;
      end else if (do_shift) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sr_q  <= BUFFER_RST;
      sdo_q <= 1'b0;
    end else if (wr_accept) begin
      sr_q  <= reg_wdata_i; // [R18]
      sdo_q <= reg_wdata_i[7]; // [R06]
    end else begin
      if (do_shift) begin
        sr_q <= shifted; // [R03]
      end
      if (xmit_edge) begin
        sdo_q <= do_shift ? sr_q[6] : sr_q[7]; // [R05]
      end
    end
  end

  // ==========================================================================
  // Buffer and status flags; hardware set wins over software clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_q <= BUFFER_RST;
      bf_q  <= STATUS_RST[STA_BF];
    end else begin
      if (complete && !(is_slave && bf_q)) begin
        buf_q <= shifted; // [R17]
        bf_q  <= 1'b1;
      end else begin
        if (wr_accept) begin
          buf_q <= reg_wdata_i; // [R18]
        end
        if (rd_buf) begin
          bf_q <= 1'b0; // [R25]
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_collision_q <= CONTROL_RST[CTL_WRITE_COLLISION];
      ovf_q  <= CONTROL_RST[CTL_OVF];
      tdf_q  <= AUX_RST[AUX_TDF];
    end else begin
      write_collision_q <= (wr_buf && busy) || (wr_ctl ? (write_collision_q && reg_wdata_i[CTL_WRITE_COLLISION]) : write_collision_q); // [R21]
      ovf_q  <= (complete && is_slave && bf_q)
                || (wr_ctl ? (ovf_q && reg_wdata_i[CTL_OVF]) : ovf_q); // [R22]
      tdf_q  <= complete || (wr_aux ? (tdf_q && reg_wdata_i[AUX_TDF]) : tdf_q); // [R25]
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q     <= CONTROL_RST[CTL_EN]; // [R15]
      ckp_q    <= CONTROL_RST[CTL_CKP];
      mode_q   <= CONTROL_RST[3:0];
      smp_q    <= STATUS_RST[STA_SMP];
      cke_q    <= STATUS_RST[STA_CKE];
      irq_en_q <= AUX_RST[AUX_IRQ_EN];
    end else begin
      if (wr_ctl) begin
        en_q   <= reg_wdata_i[CTL_EN];
        ckp_q  <= reg_wdata_i[CTL_CKP];
        mode_q <= reg_wdata_i[3:0];
      end
      if (wr_sta) begin
        smp_q <= reg_wdata_i[STA_SMP];
        cke_q <= reg_wdata_i[STA_CKE];
      end
      if (wr_aux) begin
        irq_en_q <= reg_wdata_i[AUX_IRQ_EN];
      end
    end
  end

  // Read data stand for the one cycle after the read strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (!reg_rd_i) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr_i)
        ADDR_CONTROL: rdata_q <= {write_collision_q, ovf_q, en_q, ckp_q, mode_q};
        ADDR_STATUS:  rdata_q <= {smp_q, cke_q, 5'h00, bf_q};
        ADDR_BUFFER:  rdata_q <= buf_q;
        default:      rdata_q <= {6'h00, irq_en_q, tdf_q};
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_o        = rdata_q;
  assign sck_o              = sck_q;
  assign sck_oe_o           = is_master; // [R01]
  assign serial_output_o    = sdo_q;
  // Select release floats the output two clocks after the pin rises
  assign serial_output_oe_o = !sdo_as_input_i && (is_master || slave_go); // [R10] [R19]
  assign transfer_done_o    = tdf_q;
  assign wake_o             = tdf_q && irq_en_q; // [R14]

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_master_load;
    is_master && !busy && wr_buf;
  endsequence

  chk_collision_sets_flag: assert property ( // [R21]
    (wr_buf && busy) |=> write_collision_q && $stable(sr_q))
    else $error("busy buffer write not flagged or not ignored");

  chk_master_write_starts: assert property ( // [R02]
    s_master_load |=> m_run && sr_q == $past(reg_wdata_i) && buf_q == $past(reg_wdata_i))
    else $error("master buffer write did not start a transfer");

  chk_first_bit_ready: assert property ( // [R06]
    s_master_load |=> sdo_q == $past(reg_wdata_i[7]) && sck_q == ckp_q)
    else $error("first output bit not ready before clock edge");

  chk_select_floats_out: assert property ( // [R10]
    (ss_mode && ss_n_s) |-> !serial_output_oe_o)
    else $error("output driven while select is high");

  chk_select_resets_count: assert property ( // [R11]
    (ss_mode && ss_n_s) |=> bit_cnt_q == 3'h0 && !pend_q)
    else $error("select high did not clear bit counter");

  chk_done_sets_flag: assert property ( // [R07]
    complete |=> tdf_q && transfer_done_o)
    else $error("completed byte did not set done flag");

  chk_overflow_keeps_buf: assert property ( // [R22]
    (complete && is_slave && bf_q) |=> ovf_q && $stable(buf_q))
    else $error("overflow not flagged or buffer overwritten");

  chk_receive_loads_buf: assert property ( // [R17]
    (complete && !(is_slave && bf_q)) |=> bf_q && buf_q == $past(shifted))
    else $error("completed byte not moved to buffer");

  chk_read_clears_full: assert property ( // [R25]
    (rd_buf && !complete) |=> !bf_q)
    else $error("buffer read did not clear full bit");

  chk_sleep_freezes_clock: assert property ( // [R13]
    (m_run && sleep_i) [*3] |-> $stable(sck_q) && $stable(half_cnt_q))
    else $error("master clock moved during sleep");

  chk_disable_aborts: assert property ( // [R15]
    (!en_q && !wr_ctl) |=> !m_run && bit_cnt_q == 3'h0 && !sck_oe_o)
    else $error("disabled port still transferring");

endmodule

/* test/spi_ext_master.sv */
`timescale 1ns/1ps
module spi_ext_master (
  // Serial pins seen from the far side
  output logic      sck_o,
  output logic      mosi_o,
  output logic      ss_n_o,
  input  wire logic miso_i
);
  localparam real HALF_NS = 62.5;

  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end

  // ==========================================================================
  // Clock parked at idle level before the port is enabled as slave
  task automatic park(input logic clock_polarity);
    sck_o = clock_polarity;
  endtask

  // One frame of nbits; clock stands still between frames
  task automatic xfer(input logic clock_polarity, input logic cke, input logic use_ss,
                      input int nbits, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    sck_o = clock_polarity;
    if (use_ss) ss_n_o = 1'b0;
    #(HALF_NS);
    for (int i = 7; i > 7 - nbits; i--) begin
      if (cke) begin
        mosi_o = tx[i];
        #(HALF_NS);
        sck_o = ~clock_polarity;
        rx[i] = miso_i;
        #(HALF_NS);
        sck_o = clock_polarity;
      end else begin
        sck_o = ~clock_polarity;
        mosi_o = tx[i];
        #(HALF_NS);
        sck_o = clock_polarity;
        rx[i] = miso_i;
        #(HALF_NS);
      end
    end
    // Released data line shows the inverse of its last value
    mosi_o = ~mosi_o;
    ss_n_o = 1'b1;
    #(HALF_NS);
  endtask
endmodule

/* test/sync_serial_spi_port_tb_top.sv */
`timescale 1ns/1ps
module sync_serial_spi_port_tb_top
  import spi_port_pkg::*;
;
  typedef struct {
    logic [3:0] mode;
    logic       clock_polarity;
    logic       cke;
    logic       sample_phase;
    logic [7:0] tx;
    int         half;
  } row_t;

  logic       sys_clk_i, rst_i, reg_wr_i, reg_rd_i, sleep_i;
  logic       timer_two_output_i, sdo_as_input_i, transfer_done_o, wake_o;
  logic       sck_o, sck_oe_o, serial_output_o, serial_output_oe_o, serial_input_i;
  logic [1:0] reg_addr_i, in_sel;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  wire  logic ext_sck, ext_mosi, ext_ss_n;
  wire  logic miso = serial_output_oe_o ? serial_output_o : 1'bz;
  logic [1:0] tdiv = 2'h0;
  logic       sck_prev, first_sdo;
  int         miscompares, n_compared, cyc, edges, min_gap, last_cyc;

  row_t rows [5] = '{'{4'h0, 1'b0, 1'b1, 1'b0, 8'ha5, HALF_DIV4_CYC},
                     '{4'h1, 1'b0, 1'b0, 1'b1, 8'h3c, HALF_DIV16_CYC},
                     '{4'h2, 1'b1, 1'b1, 1'b0, 8'h81, HALF_DIV64_CYC},
                     '{4'h3, 1'b1, 1'b0, 1'b1, 8'h5a, 3},
                     '{4'h0, 1'b1, 1'b1, 1'b1, 8'h7e, HALF_DIV4_CYC}};

  // Loopback for master rows, far side for slave tests, or a steady high
  assign serial_input_i = (in_sel == 2'h0) ? serial_output_o :
                          (in_sel == 2'h1) ? ext_mosi : 1'b1;

  sync_serial_spi_port u_dut (
    .sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .sleep_i, .timer_two_output_i, .sdo_as_input_i,
    .transfer_done_o, .wake_o, .sck_i(ext_sck), .sck_o, .sck_oe_o,
    .serial_input_i, .serial_output_o, .serial_output_oe_o,
    .slave_select_n_i(ext_ss_n)
  );

  spi_ext_master m (.sck_o(ext_sck), .mosi_o(ext_mosi), .ss_n_o(ext_ss_n), .miso_i(miso));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================================
  // Timer pulse every third cycle, serial clock edge monitor, hang guard
  always @(posedge sys_clk_i) begin
    timer_two_output_i <= (tdiv == 2'h2);
    tdiv <= (tdiv == 2'h2) ? 2'h0 : tdiv + 2'h1;
  end

  always @(negedge sys_clk_i) begin
    cyc++;
    if (sck_o !== sck_prev) begin
      if (edges == 0) first_sdo = serial_output_o;
      else if (cyc - last_cyc < min_gap) min_gap = cyc - last_cyc;
      edges++;
      last_cyc = cyc;
    end
    sck_prev = sck_o;
  end

  always @(negedge sys_clk_i) begin
    if (cyc > 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================================================
  // Bus and comparison helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (transfer_done_o !== 1'b1 && n < 3000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask

  task automatic mon_clr();
    edges = 0;
    min_gap = 1000;
    sck_prev = sck_o;
  endtask

  task automatic summarize();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    row_t       r;
    logic [7:0] rx;
    int         e0;
    rst_i = 1'b1;
    reg_addr_i = 2'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    sleep_i = 1'b0;
    timer_two_output_i = 1'b0;
    sdo_as_input_i = 1'b0;
    in_sel = 2'h0;
    miscompares = 0;
    n_compared = 0;
    cyc = 0;
    mon_clr();
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rchk(ADDR_CONTROL, CONTROL_RST);
    rchk(ADDR_STATUS, STATUS_RST);
    rchk(ADDR_AUX, AUX_RST);
    for (int k = 0; k < 5; k++) begin
      r = rows[k];
      wr(ADDR_CONTROL, {2'b00, 1'b1, r.clock_polarity, r.mode});
      wr(ADDR_STATUS, {r.sample_phase, r.cke, 6'h00});
      // Loopback through the synchroniser is too slow for mid-bit sampling at /4
      in_sel <= (r.half == HALF_DIV4_CYC && !r.sample_phase) ? 2'h2 : 2'h0;
      rchk(ADDR_STATUS, {r.sample_phase, r.cke, 6'h00});
      check({7'h00, sck_o}, {7'h00, r.clock_polarity});
      mon_clr();
      wr(ADDR_BUFFER, r.tx);
      wr(ADDR_BUFFER, ~r.tx);
      wait_done();
      rchk(ADDR_CONTROL, {2'b10, 1'b1, r.clock_polarity, r.mode});
      rchk(ADDR_STATUS, {r.sample_phase, r.cke, 6'h01});
      rchk(ADDR_BUFFER, (in_sel == 2'h2) ? 8'hff : r.tx);
      rchk(ADDR_STATUS, {r.sample_phase, r.cke, 6'h00});
      rchk(ADDR_AUX, 8'h01);
      wr(ADDR_AUX, 8'h00);
      repeat (2 * r.half + 2) @(posedge sys_clk_i);
      check(8'(edges), 8'h10);
      check(8'(min_gap), 8'(r.half));
      if (r.cke) check({7'h00, first_sdo}, {7'h00, r.tx[7]});
      wr(ADDR_CONTROL, 8'h00);
    end
    // Master frozen in sleep resumes afterwards
    wr(ADDR_CONTROL, 8'h20);
    wr(ADDR_STATUS, 8'hc0);
    mon_clr();
    wr(ADDR_BUFFER, 8'hc9);
    repeat (6) @(posedge sys_clk_i);
    sleep_i <= 1'b1;
    // A phase tick already in flight may still land on the first sleep edge
    repeat (2) @(posedge sys_clk_i);
    e0 = edges;
    repeat (40) @(posedge sys_clk_i);
    check(8'(edges - e0), 8'h00);
    check({7'h00, transfer_done_o}, 8'h00);
    sleep_i <= 1'b0;
    wait_done();
    rchk(ADDR_BUFFER, 8'hc9);
    wr(ADDR_AUX, 8'h00);
    // Receive-only master
    sdo_as_input_i <= 1'b1;
    in_sel <= 2'h2;
    wr(ADDR_BUFFER, 8'h00);
    check({7'h00, serial_output_oe_o}, 8'h00);
    wait_done();
    rchk(ADDR_STATUS, 8'hc1);
    rchk(ADDR_BUFFER, 8'hff);
    sdo_as_input_i <= 1'b0;
    in_sel <= 2'h1;
    wr(ADDR_CONTROL, 8'h00);
    // Select-controlled slave, shifting while asleep
    m.park(1'b0);
    wr(ADDR_CONTROL, 8'h24);
    wr(ADDR_STATUS, 8'h40);
    wr(ADDR_AUX, 8'h02);
    check({7'h00, serial_output_oe_o}, 8'h00);
    wr(ADDR_BUFFER, 8'h3c);
    sleep_i <= 1'b1;
    m.xfer(1'b0, 1'b1, 1'b1, 8, 8'ha5, rx);
    repeat (6) @(posedge sys_clk_i);
    check(rx, 8'h3c);
    check({7'h00, wake_o}, 8'h01);
    sleep_i <= 1'b0;
    rchk(ADDR_BUFFER, 8'ha5);
    // Overflow keeps the unread byte
    m.xfer(1'b0, 1'b1, 1'b1, 8, 8'h11, rx);
    m.xfer(1'b0, 1'b1, 1'b1, 8, 8'h22, rx);
    repeat (6) @(posedge sys_clk_i);
    rchk(ADDR_CONTROL, 8'h64);
    rchk(ADDR_BUFFER, 8'h11);
    wr(ADDR_CONTROL, 8'h24);
    // Select rises after four bits
    m.xfer(1'b0, 1'b1, 1'b1, 4, 8'hf0, rx);
    check({7'h00, serial_output_oe_o}, 8'h00);
    m.xfer(1'b0, 1'b1, 1'b1, 8, 8'h96, rx);
    repeat (6) @(posedge sys_clk_i);
    rchk(ADDR_BUFFER, 8'h96);
    wr(ADDR_CONTROL, 8'h00);
    // Slave without select, other polarity and edge
    m.park(1'b1);
    wr(ADDR_CONTROL, 8'h35);
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_BUFFER, 8'hc3);
    m.xfer(1'b1, 1'b0, 1'b0, 8, 8'h69, rx);
    repeat (6) @(posedge sys_clk_i);
    check(rx, 8'hc3);
    rchk(ADDR_BUFFER, 8'h69);
    // Reset in mid-transfer
    wr(ADDR_CONTROL, 8'h20);
    in_sel <= 2'h0;
    wr(ADDR_BUFFER, 8'h5a);
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    check({7'h00, sck_oe_o}, 8'h00);
    rchk(ADDR_CONTROL, CONTROL_RST);
    rchk(ADDR_AUX, AUX_RST);
    summarize();
  end
endmodule
